// ==== rtl/sdi_rx_status.sv ====
// Receive status top: ancillary lane mapping, format report and APB registers
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "sdi_rx_defs.svh"
module sdi_rx_status
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [39:0] rx_data_i,
    input  wire logic        rx_word_en_i,
    input  wire logic [10:0] active_lines_i,
    input  wire logic        rate_frac_i,
    output logic      [39:0] anc_data_o,
    output logic      [3:0]  anc_valid_o,
    output logic      [3:0]  anc_error_o,
    output logic      [7:0]  video_format_o,
    output logic             trs_o,
    output logic             irq_o
);
    import sdi_rx_pkg::*;

    anc_chan_if ch [4] ();

    logic [3:0]  ctrl;
    logic [2:0]  mask;
    logic [2:0]  status;
    logic [12:0] word_cnt;
    logic [12:0] line_words;
    logic [10:0] since_f;
    logic        interlaced;
    logic [7:0]  fmt_code;
    logic [1:0]  lane_y;
    logic [1:0]  cur_y;
    logic [9:0]  prev_word [2];
    logic [3:0]  used;
    logic [3:0]  out_stb;
    logic [3:0]  valid_v;
    logic [3:0]  err_v;
    logic [3:0]  done_v;
    logic        access;
    logic        mapped;
    logic        rd_status;
    mode_t       mode;

    // Lane L of the data bus
    function automatic logic [9:0] lane(input logic [39:0] d, input int l);
        lane = d[10*l +: 10];
    endfunction : lane

    // Modes with a Cb,Y,Cr,Y multiplex split into Y and C sub-streams
    function automatic logic muxed(input mode_t m);
        muxed = (m == mode_3gb);
    endfunction : muxed

    always_comb
    begin
        unique case (ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB])
            3'h1:    mode = mode_hd;
            3'h2:    mode = mode_dual;
            3'h3:    mode = mode_3ga;
            3'h4:    mode = mode_3gb;
            default: mode = mode_sd;
        endcase
    end

    // Channels in use per mode
    always_comb
    begin
        unique case (mode)
            mode_sd:   used = 4'b0001;
            mode_hd:   used = 4'b0011;
            mode_3ga:  used = 4'b0011;
            mode_dual: used = 4'b1111;
            mode_3gb:  used = 4'b1111;
        endcase
        used = ctrl[`CTRL_EN_BIT] ? used : 4'b0000;
    end

    // The first 3FF of a preamble is always a C word
    always_comb
    begin
        for (int l = 0; l < 2; l++)
        begin
            cur_y[l] = (lane(rx_data_i, l) == `WORD_3FF && prev_word[l] != `WORD_3FF)
                       ? 1'b0 : lane_y[l];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            lane_y       <= 2'b00;
            prev_word[0] <= 10'h0;
            prev_word[1] <= 10'h0;
        end
        else if (rx_word_en_i)
        begin
            lane_y       <= ~cur_y;
            prev_word[0] <= lane(rx_data_i, 0);
            prev_word[1] <= lane(rx_data_i, 1);
        end
    end

    genvar k;
    generate
        for (k = 0; k < 4; k++)
        begin : g_chan
            // In 3G-B parsers 3,2 take link A Y,C and parsers 1,0 link B Y,C
            always_comb
            begin
                if (muxed(mode))
                begin
                    ch[k].word = lane(rx_data_i, k / 2);
                    ch[k].stb  = rx_word_en_i & used[k] & (cur_y[k / 2] == 1'(k % 2));
                end
                else
                begin
                    ch[k].word = lane(rx_data_i, k);
                    ch[k].stb  = rx_word_en_i & used[k];
                end
            end

            anc_packet_parser u_parser
            (
                .clock_i (clock_i),
                .rst_i   (rst_i),
                .ch      (ch[k])
            );

            assign out_stb[k] = ch[k].out_stb;
            assign valid_v[k] = ch[k].valid;
            assign err_v[k]   = ch[k].err;
            assign done_v[k]  = ch[k].done;
        end
    endgenerate

    logic [9:0] out_word_v [4];
    assign out_word_v[0] = ch[0].out_word;
    assign out_word_v[1] = ch[1].out_word;
    assign out_word_v[2] = ch[2].out_word;
    assign out_word_v[3] = ch[3].out_word;

    // Parser output word by channel number
    function automatic logic [9:0] ch_word(input int n);
        ch_word = out_word_v[n];
    endfunction : ch_word

    // Data lanes; unused lanes stay low
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            anc_data_o <= 40'h0;
        end
        else
        begin
            for (int l = 0; l < 4; l++)
            begin
                if (!used[l] || (muxed(mode) && l >= 2))
                begin
                    anc_data_o[10*l +: 10] <= 10'h0;
                end
                else if (muxed(mode))
                begin
                    if (out_stb[2*l + 1])
                    begin
                        anc_data_o[10*l +: 10] <= ch_word(2*l + 1);
                    end
                    else if (out_stb[2*l])
                    begin
                        anc_data_o[10*l +: 10] <= ch_word(2*l);
                    end
                end
                else if (out_stb[l])
                begin
                    // SD: lane 0 only; HD/3GA: Y on 1, C on 0; dual: all four
                    anc_data_o[10*l +: 10] <= ch_word(l);
                end
            end
        end
    end

    // Flags follow the parser channel numbering, masked to the mode
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            anc_valid_o <= 4'h0;
            anc_error_o <= 4'h0;
        end
        else
        begin
            anc_valid_o <= valid_v & used;
            anc_error_o <= err_v & used;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            trs_o <= 1'b0;
        end
        else
        begin
            trs_o <= ch[0].out_stb & ch[0].trs & used[0];
        end
    end

    // Words per line, EAV to EAV, on channel 0
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            word_cnt   <= 13'h0;
            line_words <= 13'h0;
        end
        else if (ch[0].out_stb)
        begin
            if (ch[0].eav)
            begin
                line_words <= word_cnt;
                word_cnt   <= 13'h1;
            end
            else if (word_cnt != 13'h1fff)
            begin
                word_cnt <= 13'(word_cnt + 13'h1);
            end
        end
    end

    // Interlace seen while the field bit is set at an EAV within every 2048 lines
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            since_f    <= 11'h0;
            interlaced <= 1'b0;
        end
        else if (ch[0].out_stb && ch[0].eav)
        begin
            if (ch[0].field)
            begin
                since_f    <= 11'h0;
                interlaced <= 1'b1;
            end
            else if (since_f == `PROG_TIMEOUT)
            begin
                interlaced <= 1'b0;
            end
            else
            begin
                since_f <= 11'(since_f + 11'h1);
            end
        end
    end

    format_classifier u_format
    (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .sd_i         (mode == mode_sd),
        .words_i      (line_words),
        .lines_i      (active_lines_i),
        .interlaced_i (interlaced),
        .frac_i       (rate_frac_i),
        .code_o       (fmt_code)
    );

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            video_format_o <= `FMT_SD;
        end
        else
        begin
            video_format_o <= fmt_code;
        end
    end

    // APB: one wait state, access completes at the edge with pready high
    assign access    = psel_i & penable_i & pready_o;
    assign rd_status = access & ~pwrite_i & (paddr_i == `REG_STATUS);
    assign mapped    = paddr_i inside {`REG_CTRL, `REG_FORMAT, `REG_STATUS, `REG_MASK,
                                       `REG_LINE_WORDS};

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end
        else
        begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
            prdata_o  <= 32'h0;
            if (psel_i && penable_i && !pready_o && !pwrite_i)
            begin
                unique case (paddr_i)
                    `REG_CTRL:       prdata_o <= {28'h0, ctrl};
                    `REG_FORMAT:     prdata_o <= {24'h0, video_format_o};
                    `REG_STATUS:     prdata_o <= {29'h0, status};
                    `REG_MASK:       prdata_o <= {29'h0, mask};
                    `REG_LINE_WORDS: prdata_o <= {19'h0, line_words};
                    default:         prdata_o <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ctrl <= `CTRL_RESET;
            mask <= `MASK_RESET;
        end
        else if (access && pwrite_i)
        begin
            if (paddr_i == `REG_CTRL)
            begin
                ctrl <= pwdata_i[3:0];
            end
            if (paddr_i == `REG_MASK)
            begin
                mask <= pwdata_i[2:0];
            end
        end
    end

    // Sticky events; a new event wins over the read clear
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            status <= 3'h0;
        end
        else
        begin
            status <= (rd_status ? 3'h0 : status)
                    | {video_format_o != fmt_code, |(done_v & used), |(err_v & used)};
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(status & mask);
        end
    end
endmodule : sdi_rx_status

// ==== rtl/sdi_rx_defs.svh ====
// Register map, field positions, reset values and word codes of the receive status block
`ifndef SDI_RX_DEFS_SVH
`define SDI_RX_DEFS_SVH
`define REG_CTRL       8'h00
`define REG_FORMAT     8'h04
`define REG_STATUS     8'h08
`define REG_MASK       8'h0c
`define REG_LINE_WORDS 8'h10
`define CTRL_EN_BIT    0
`define CTRL_MODE_LSB  1
`define CTRL_MODE_MSB  3
`define CTRL_RESET     4'h1
`define MASK_RESET     3'h0
`define ST_ANC_ERR     0
`define ST_PKT_DONE    1
`define ST_FMT_CHG     2
`define WORD_3FF       10'h3ff
`define WORD_000       10'h000
`define XYZ_F_BIT      8
`define XYZ_H_BIT      6
`define PROG_TIMEOUT   11'h7ff
`define FMT_SD         8'h08
`define FAM_1080       3'h1
`define FAM_720        3'h2
`define FAM_1035       3'h3
`define FAM_1080I25    3'h4
`define RATE_60        4'h7
`define RATE_5994      4'h6
`define RATE_50        4'h5
`define RATE_30        4'h4
`define RATE_2997      4'h3
`define RATE_25        4'h2
`define RATE_24        4'h1
`define RATE_2397      4'h0
`define LINES_720      11'h2d0
`define LINES_1035     11'h40b
`define LINES_1080     11'h438
`define WPL_1650       13'h0672
`define WPL_1980       13'h07bc
`define WPL_2200       13'h0898
`define WPL_2376       13'h0948
`define WPL_2640       13'h0a50
`define WPL_2750       13'h0abe
`define WPL_3300       13'h0ce4
`define WPL_3960       13'h0f78
`define WPL_4120       13'h1018
`define WPL_4125       13'h101d
`endif

// ==== rtl/sdi_rx_pkg.sv ====
// Types shared by the receive status block
package sdi_rx_pkg;
    typedef enum logic [2:0] {mode_sd, mode_hd, mode_dual, mode_3ga, mode_3gb} mode_t;
    typedef enum logic [2:0] {p_idle, p_skip1, p_skip2, p_did, p_sdid, p_dc, p_udw, p_cs}
        parse_state_t;
endpackage : sdi_rx_pkg

// ==== rtl/anc_chan_if.sv ====
// One ancillary channel between the top and its packet parser
`timescale 1ns/10ps
interface anc_chan_if;
    logic [9:0] word;
    logic       stb;
    logic [9:0] out_word;
    logic       out_stb;
    logic       valid;
    logic       err;
    logic       done;
    logic       trs;
    logic       eav;
    logic       field;
    modport parser (input word, stb,
                    output out_word, out_stb, valid, err, done, trs, eav, field);
    modport host   (output word, stb,
                    input out_word, out_stb, valid, err, done, trs, eav, field);
endinterface : anc_chan_if

// ==== rtl/anc_packet_parser.sv ====
// Ancillary packet and timing-reference parser for one word stream
`timescale 1ns/10ps
`include "sdi_rx_defs.svh"
module anc_packet_parser
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    anc_chan_if.parser      ch
);
    import sdi_rx_pkg::*;

    parse_state_t state;
    logic [9:0]   w0, w1, w2, w3;
    logic [8:0]   sum;
    logic [7:0]   left;
    logic         perr;
    logic         trs_here;

    // Parity bit 8 even over 7:0, bit 9 its inverse
    function automatic logic bad_parity(input logic [9:0] w);
        bad_parity = (w[8] != ^w[7:0]) | (w[9] == w[8]);
    endfunction : bad_parity

    assign trs_here = (w0 == `WORD_3FF) && (w1 == `WORD_000) && (w2 == `WORD_000);

    // Four-word look-ahead so the preamble is flagged on its first word
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            {w0, w1, w2, w3} <= 40'h0;
        end
        else if (ch.stb)
        begin
            {w0, w1, w2, w3} <= {w1, w2, w3, ch.word};
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ch.out_word <= 10'h0;
            ch.out_stb  <= 1'b0;
            ch.trs      <= 1'b0;
            ch.eav      <= 1'b0;
            ch.field    <= 1'b0;
        end
        else
        begin
            ch.out_stb <= ch.stb;
            if (ch.stb)
            begin
                ch.out_word <= w0;
                ch.trs      <= trs_here;
                ch.eav      <= trs_here & w3[`XYZ_H_BIT];
                ch.field    <= w3[`XYZ_F_BIT];
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state    <= p_idle;
            sum      <= 9'h0;
            left     <= 8'h0;
            perr     <= 1'b0;
            ch.valid <= 1'b0;
            ch.err   <= 1'b0;
            ch.done  <= 1'b0;
        end
        else if (!ch.stb)
        begin
            ch.valid <= 1'b0;
            ch.err   <= 1'b0;
            ch.done  <= 1'b0;
        end
        else
        begin
            ch.valid <= state inside {p_did, p_sdid, p_dc, p_udw};
            ch.err   <= 1'b0;
            ch.done  <= 1'b0;
            if (state inside {p_did, p_sdid, p_dc, p_udw})
            begin
                sum <= (state == p_did) ? w0[8:0] : 9'(sum + w0[8:0]);
            end
            if (state inside {p_did, p_sdid, p_dc})
            begin
                perr <= ((state == p_did) ? 1'b0 : perr) | bad_parity(w0);
            end
            if (trs_here)
            begin
                state <= p_idle;
            end
            else
            begin
                unique case (state)
                    p_idle:
                    begin
                        if (w0 == `WORD_000 && w1 == `WORD_3FF && w2 == `WORD_3FF)
                        begin
                            state <= p_skip1;
                        end
                    end
                    p_skip1: state <= p_skip2;
                    p_skip2: state <= p_did;
                    p_did:   state <= p_sdid;
                    p_sdid:  state <= p_dc;
                    p_dc:
                    begin
                        left  <= w0[7:0];
                        state <= (w0[7:0] == 8'h0) ? p_cs : p_udw;
                    end
                    p_udw:
                    begin
                        left <= 8'(left - 8'h1);
                        if (left == 8'h1)
                        begin
                            state <= p_cs;
                        end
                    end
                    p_cs:
                    begin
                        ch.err  <= perr | (w0[8:0] != sum) | (w0[9] == w0[8]);
                        ch.done <= 1'b1;
                        state   <= p_idle;
                    end
                endcase
            end
        end
    end
endmodule : anc_packet_parser

// ==== rtl/format_classifier.sv ====
// Maps measured line length and line count to the 8-bit video format code
`timescale 1ns/10ps
`include "sdi_rx_defs.svh"
module format_classifier
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        sd_i,
    input  wire logic [12:0] words_i,
    input  wire logic [10:0] lines_i,
    input  wire logic        interlaced_i,
    input  wire logic        frac_i,
    output logic      [7:0]  code_o
);
    // Whole and fractional rate pairs share a line length
    function automatic logic [3:0] pick(input logic frac, input logic [3:0] w,
                                        input logic [3:0] f);
        pick = frac ? f : w;
    endfunction : pick

    logic [2:0] fam;
    logic [3:0] rate;

    always_comb
    begin
        fam  = `FAM_1080;
        rate = `RATE_2397;
        if (lines_i == `LINES_720)
        begin
            fam = `FAM_720;
            unique case (words_i)
                `WPL_1650: rate = pick(frac_i, `RATE_60, `RATE_5994);
                `WPL_1980: rate = `RATE_50;
                `WPL_3300: rate = pick(frac_i, `RATE_30, `RATE_2997);
                `WPL_3960: rate = `RATE_25;
                `WPL_4125: rate = `RATE_24;
                default:   rate = `RATE_2397;
            endcase
        end
        else
        begin
            if (lines_i == `LINES_1035)
            begin
                fam = `FAM_1035;
            end
            else if (interlaced_i && words_i == `WPL_2376)
            begin
                fam = `FAM_1080I25;
            end
            unique case (words_i)
                `WPL_2200: rate = (interlaced_i && lines_i != `LINES_1035)
                                  ? pick(frac_i, `RATE_60, `RATE_5994)
                                  : pick(frac_i, `RATE_30, `RATE_2997);
                `WPL_2640: rate = interlaced_i ? `RATE_50 : `RATE_25;
                `WPL_2376: rate = `RATE_25;
                `WPL_2750: rate = pick(frac_i, `RATE_24, `RATE_2397);
                default:   rate = `RATE_2397;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            code_o <= `FMT_SD;
        end
        else
        begin
            code_o <= sd_i ? `FMT_SD : {fam, ~interlaced_i, rate};
        end
    end
endmodule : format_classifier

// ==== verif/sdi_rx_status_sva.sv ====
// Port checks for the receive status top
`timescale 1ns/10ps
module sdi_rx_status_sva
(
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [3:0]  anc_valid_o,
    input wire logic [3:0]  anc_error_o,
    input wire logic [7:0]  video_format_o,
    input wire logic        trs_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_rst;
        disable iff (1'b0) rst_i |=> !trs_o && anc_valid_o == 4'h0 && video_format_o == 8'h08;
    endproperty
    property p_rdy;
        pready_o |-> $past(psel_i && penable_i) && $past(psel_i && !penable_i, 2);
    endproperty
    property p_pulse; pready_o |=> !pready_o; endproperty
    property p_err; pslverr_o |-> pready_o; endproperty
    property p_sd; video_format_o[7:5] == 3'h0 |-> video_format_o == 8'h08; endproperty
    property p_prog; video_format_o[4] |-> video_format_o[7:5] inside {3'h1, 3'h2}; endproperty
    property p_excl; (anc_valid_o & anc_error_o) == 4'h0; endproperty
    property p_trs; trs_o |=> !trs_o [*2]; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    a_rdy: assert property (p_rdy) else $error("ready outside access phase");
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    a_err: assert property (p_err) else $error("slave error without ready");
    a_sd: assert property (p_sd) else $error("bad code for family zero");
    a_prog: assert property (p_prog) else $error("progressive with bad family");
    a_excl: assert property (p_excl) else $error("valid and error together");
    a_trs: assert property (p_trs) else $error("timing flag too long");
    c_trs: cover property (trs_o);
    c_err: cover property (anc_error_o != 4'h0);
    c_slv: cover property (pslverr_o);
endmodule : sdi_rx_status_sva

bind sdi_rx_status sdi_rx_status_sva chk (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .anc_valid_o(anc_valid_o), .anc_error_o(anc_error_o),
    .video_format_o(video_format_o), .trs_o(trs_o));

// ==== verif/video_source.sv ====
// Video source model sending one ancillary packet per channel
`timescale 1ns/10ps
module video_source
(
    input  wire logic        clock_i,
    output logic      [39:0] rx_data_o,
    output logic             word_en_o
);
    import sdi_rx_pkg::*;
    initial
    begin
        rx_data_o = 40'h0;
        word_en_o = 1'b0;
    end
    // Preamble, packet with DC of one, then fillers
    function automatic logic [9:0] wd(input int c, input int i, input logic bad);
        logic [9:0] u;
        logic [8:0] s;
        u = 10'h0c0 | 10'(c);
        s = 9'h041 + 9'h005 + 9'h101 + u[8:0];
        case (i)
            0, 5, 6: wd = 10'h3ff;
            1, 2, 4: wd = 10'h000;
            3: wd = 10'h200;
            7: wd = 10'h241;
            8: wd = 10'h205;
            9: wd = 10'h101;
            10: wd = u;
            11: wd = {~s[8], s} ^ {9'h0, bad};
            default: wd = 10'h040;
        endcase
    endfunction : wd
    task automatic send(input mode_t m, input logic [3:0] bad);
        for (int i = 0; i < 20; i++)
            for (int p = 0; p < ((m == mode_3gb) ? 2 : 1); p++)
            begin
                @(posedge clock_i);
                word_en_o <= 1'b1;
                if (m == mode_3gb)
                    rx_data_o <= {20'h0, wd(2 + p, i, bad[2 + p]), wd(p, i, bad[p])};
                else
                    rx_data_o <= {wd(3, i, bad[3]), wd(2, i, bad[2]), wd(1, i, bad[1]),
                                  wd(0, i, bad[0])};
            end
        @(posedge clock_i);
        word_en_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
    endtask : send
endmodule : video_source

// ==== verif/tb.sv ====
// Self-checking bench for the receive status top
`timescale 1ns/10ps
module tb;
    import sdi_rx_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  paddr_i = 8'h00;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic        pready_o, pslverr_o, trs_o, irq_o, rx_word_en_i, er;
    logic [39:0] rx_data_i, anc_data_o, used;
    logic [3:0]  anc_valid_o, anc_error_o;
    logic [7:0]  video_format_o;
    logic [9:0]  vlast [4];
    int          vcnt [4], ecnt [4];
    int          tcnt, stray, fails = 0, total_checks = 0;
    mode_t       cur = mode_sd;
    always #4 clock_i = ~clock_i;
    sdi_rx_status uut (.clock_i(clock_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_data_i(rx_data_i),
        .rx_word_en_i(rx_word_en_i), .active_lines_i(11'h438), .rate_frac_i(1'b0),
        .anc_data_o(anc_data_o), .anc_valid_o(anc_valid_o), .anc_error_o(anc_error_o),
        .video_format_o(video_format_o), .trs_o(trs_o), .irq_o(irq_o));
    video_source src (.clock_i(clock_i), .rx_data_o(rx_data_i), .word_en_o(rx_word_en_i));
    always_comb used = (cur == mode_sd) ? 40'h3ff : (cur == mode_dual) ? '1 : 40'hfffff;
    // Per-flag pulse counts and last valid word of its lane
    always @(posedge clock_i)
    begin
        for (int b = 0; b < 4; b++)
        begin
            if (anc_valid_o[b] === 1'b1)
            begin
                vcnt[b]++;
                vlast[b] = anc_data_o[10 * ((cur == mode_3gb) ? b / 2 : b) +: 10];
            end
            if (anc_error_o[b] === 1'b1)
                ecnt[b]++;
        end
        if (trs_o === 1'b1)
            tcnt++;
        if ((anc_data_o & ~used) !== 40'h0)
            stray++;
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge clock_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do
            @(posedge clock_i);
        while (pready_o !== 1'b1 && ++n < 20);
        if (n >= 20)
        begin
            fails++;
            test_done;
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task run(input mode_t m, input logic en, input logic [3:0] bad);
        logic [3:0] act;
        act = (m == mode_sd) ? 4'h1 : (m == mode_dual || m == mode_3gb) ? 4'hf : 4'h3;
        if (!en)
            act = 4'h0;
        cur = m;
        apb(1'b1, 8'h00, {28'h0, m, en}, rd, er);
        // Lanes of the old mode clear one cycle after the write
        repeat (2) @(posedge clock_i);
        vcnt = '{default: 0};
        ecnt = '{default: 0};
        tcnt = 0;
        stray = 0;
        src.send(m, bad);
        repeat (12) @(posedge clock_i);
        for (int b = 0; b < 4; b++)
        begin
            chk("valid count", vcnt[b], act[b] ? 32'd4 : 32'd0);
            chk("error count", ecnt[b], {31'h0, act[b] & bad[b]});
            if (act[b])
                chk("last word", {22'h0, vlast[b]}, 32'h0c0 | b);
        end
        chk("trs count", tcnt, {31'h0, en});
        chk("stray bits", stray, 32'h0);
    endtask : run
    initial
    begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk("format pin", {24'h0, video_format_o}, 32'h08);
        apb(1'b0, 8'h00, 32'h0, rd, er);
        chk("ctrl reset", rd, 32'h1);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk("format reg", rd, 32'h08);
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk("unmapped err", {31'h0, er}, 32'h1);
        run(mode_sd, 1'b1, 4'h1);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk("status", rd & 32'h3, 32'h3);
        apb(1'b1, 8'h0c, 32'h2, rd, er);
        run(mode_hd, 1'b1, 4'h2);
        chk("irq set", {31'h0, irq_o}, 32'h1);
        chk("format hd", {24'h0, video_format_o}, 32'h30);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk("status", rd & 32'h3, 32'h3);
        repeat (2) @(posedge clock_i);
        chk("irq clear", {31'h0, irq_o}, 32'h0);
        run(mode_dual, 1'b1, 4'h8);
        run(mode_3ga, 1'b1, 4'h0);
        run(mode_3gb, 1'b1, 4'h5);
        run(mode_hd, 1'b0, 4'h3);
        test_done;
    end
endmodule : tb
